//--- verilog/lep_pkg.sv
package lep_pkg;
   // one-shot pulse length stand-in for external timing parts, in ns
   localparam int PULSE_NS = 1000;
   localparam int CLK_NS = 25;
   localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int PULSE_W = 16;
   localparam logic [PULSE_W-1:0] CNT_ZERO = 16'h0000;
   localparam logic [PULSE_W-1:0] CNT_ONE = 16'h0001;
   localparam logic Q_RST = 1'h0;
   typedef enum logic [1:0] {OS_IDLE, OS_FIRE} lep_os_t;
endpackage : lep_pkg

//--- verilog/lep_top.sv
// Function
// - and-or-invert output low when any and group is fully high
// - xor output is one exactly when the two inputs differ
// - gated one-shot fires on falling neg trigger or rising pos trigger
// - fired gated pulse ignores inputs until its duration elapses
// - retriggerable clear low resets output and blocks firing
// - rising clear fires when neg trigger low and pos trigger high
// - pos trigger during pulse restarts the pulse timing
// - dual one-shot has two independent channels, one trigger pair each
// - rs flop sets on both set gates high or direct set
// - rs flop clears on both reset gates high or direct clear
// - rs flop changes only on falling clock or a direct set or clear, else holds
// - nand latch holds on 00, 10 gives 0, 01 gives 1
// - data latch follows data while enable high, keeps last value
// - data latch ignores data while enable low
// - low clear forces zero, else low preset forces one, regardless of data and enable
// - jk flop toggles when j and k both high
// - jk sets on j only, clears on k only, holds on neither
// - inverted-k variant toggles on j high and k input low
// - jk direct set and clear override clock, act immediately
`timescale 1ns/10ps

module lep_retrig_os
   import lep_pkg::*;
#(
   parameter int PULSE_LEN = PULSE_CYC
) (
   // system
   input wire logic clock,
   input wire logic rstn,
   // triggers, already synchronised
   input wire logic negTrig,
   input wire logic posTrig,
   input wire logic clearIn,
   // pulse
   output logic pulseOut
);
   logic negPrev_reg;
   logic posPrev_reg;
   logic clrPrev_reg;
   logic fire;
   logic [PULSE_W-1:0] count_reg;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         negPrev_reg <= 1'h1;
         posPrev_reg <= 1'h0;
         clrPrev_reg <= 1'h1;
      end else begin
         negPrev_reg <= negTrig;
         posPrev_reg <= posTrig;
         clrPrev_reg <= clearIn;
      end
   end

   // falling neg with pos high, rising pos with neg low, rising clear
   assign fire = clearIn && ((negPrev_reg && !negTrig && posTrig)
      || (!posPrev_reg && posTrig && !negTrig)
      || (!clrPrev_reg && !negTrig && posTrig));

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         count_reg <= CNT_ZERO;
      end else if (!clearIn) begin
         count_reg <= CNT_ZERO;
      end else if (fire) begin
         count_reg <= PULSE_W'(PULSE_LEN);
      end else if (count_reg != CNT_ZERO) begin
         count_reg <= count_reg - CNT_ONE;
      end
   end

   assign pulseOut = count_reg != CNT_ZERO;

   chk_clear_kills: assert property (@(posedge clock) disable iff (!rstn)
      !clearIn |=> !pulseOut) else $error("pulse survives clear");
   chk_retrig_extend: assert property (@(posedge clock) disable iff (!rstn)
      fire |=> count_reg == PULSE_W'(PULSE_LEN))
      else $error("retrigger did not reload");
   initial begin
      if (PULSE_LEN < 1 || PULSE_LEN >= (1 << PULSE_W)) begin
         $error("pulse length out of range");
      end
   end
endmodule : lep_retrig_os

module lep_top
   import lep_pkg::*;
#(
   parameter int PULSE_LEN = PULSE_CYC
) (
   // system
   input wire logic clock,
   input wire logic rstn,
   // and-or-invert: two 2-input groups and four 2-input groups
   input wire logic [3:0] aoiDualIn,
   output logic aoiDualOut,
   input wire logic [7:0] aoiQuadIn,
   output logic aoiQuadOut,
   // exclusive or
   input wire logic xorA,
   input wire logic xorB,
   output logic xorOut,
   // gated one-shot
   input wire logic neg_trigger_first,
   input wire logic neg_trigger_second,
   input wire logic gosPosTrig,
   output logic gosOut,
   output logic gosOutN,
   // retriggerable one-shot, two negative and two positive triggers
   input wire logic [1:0] rosNegTrig,
   input wire logic [1:0] rosPosTrig,
   input wire logic rosClearN,
   output logic rosOut,
   output logic rosOutN,
   // dual retriggerable one-shot
   input wire logic [1:0] dosNegTrig,
   input wire logic [1:0] dosPosTrig,
   input wire logic [1:0] dosClearN,
   output logic [1:0] dosOut,
   output logic [1:0] dosOutN,
   // clocked reset-set flop
   input wire logic rsClk,
   input wire logic [1:0] rsSetGate,
   input wire logic [1:0] rsResetGate,
   input wire logic rsDirectSet,
   input wire logic rsDirectClear,
   output logic rsQ,
   output logic rsQN,
   // nand latch
   input wire logic nlSet,
   input wire logic nlReset,
   output logic nlQ,
   output logic nlQN,
   // data latch
   input wire logic dlData,
   input wire logic dlEnable,
   input wire logic dlPresetN,
   input wire logic dlClearN,
   output logic dlQ,
   output logic dlQN,
   // j-k flops: [0] normal, [1] inverted-k
   input wire logic [1:0] jkClk,
   input wire logic [1:0] jkJ,
   input wire logic [1:0] jkK,
   input wire logic [1:0] direct_set_in,
   input wire logic [1:0] direct_clear_in,
   output logic [1:0] jkQ,
   output logic [1:0] jkQN
);
   // plain gates stay combinational, as the primitives they model
   assign aoiDualOut = !((&aoiDualIn[1:0]) || (&aoiDualIn[3:2]));
   assign aoiQuadOut = !((&aoiQuadIn[1:0]) || (&aoiQuadIn[3:2])
      || (&aoiQuadIn[5:4]) || (&aoiQuadIn[7:6]));
   assign xorOut = xorA ^ xorB;

   // two-flop synchronisers, reset to pin idle levels so no false edge
   localparam int NSYNC = 25;
   localparam logic [NSYNC-1:0] SYNC_IDLE = 25'h1B39800;
   logic [NSYNC-1:0] rawIn;
   logic [NSYNC-1:0] meta_reg;
   logic [NSYNC-1:0] sync_reg;
   assign rawIn = {neg_trigger_first, neg_trigger_second, gosPosTrig,
      rosNegTrig, rosPosTrig, rosClearN, dosNegTrig, dosPosTrig, dosClearN,
      rsClk, rsSetGate, rsResetGate, nlSet, nlReset, dlData, dlEnable,
      jkClk};

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         meta_reg <= SYNC_IDLE;
         sync_reg <= SYNC_IDLE;
      end else begin
         meta_reg <= rawIn;
         sync_reg <= meta_reg;
      end
   end

   logic sNeg1, sNeg2, sGPos, sRClr, sRsClk, sNlS, sNlR, sDlD, sDlE;
   logic [1:0] sRNeg, sRPos, sDNeg, sDPos, sDClr, sSetG, sRstG, sJkClk;
   assign {sNeg1, sNeg2, sGPos, sRNeg, sRPos, sRClr, sDNeg, sDPos, sDClr,
      sRsClk, sSetG, sRstG, sNlS, sNlR, sDlD, sDlE, sJkClk} = sync_reg;

   // gated one-shot
   logic gNegPrev_reg;
   logic gPosPrev_reg;
   logic gNegAnd, gFire;
   lep_os_t gState_reg;
   logic [PULSE_W-1:0] gCount_reg;
   assign gNegAnd = sNeg1 && sNeg2;
   assign gFire = (gNegPrev_reg && !gNegAnd && sGPos)
      || (!gPosPrev_reg && sGPos && !gNegAnd);

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         gNegPrev_reg <= 1'h1;
         gPosPrev_reg <= 1'h1;
      end else begin
         gNegPrev_reg <= gNegAnd;
         gPosPrev_reg <= sGPos;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         gState_reg <= OS_IDLE;
         gCount_reg <= CNT_ZERO;
      end else begin
         case (gState_reg)
            OS_IDLE: begin
               if (gFire) begin
                  gState_reg <= OS_FIRE;
                  gCount_reg <= PULSE_W'(PULSE_LEN);
               end
            end
            OS_FIRE: begin
               // inputs not looked at until the count runs out
               if (gCount_reg == CNT_ONE) begin
                  gState_reg <= OS_IDLE;
               end
               gCount_reg <= gCount_reg - CNT_ONE;
            end
            default: begin
               gState_reg <= OS_IDLE;
               gCount_reg <= CNT_ZERO;
            end
         endcase
      end
   end
   assign gosOut = gState_reg == OS_FIRE;
   assign gosOutN = !gosOut;

   // single retriggerable: and the triggers into one channel
   lep_retrig_os #(.PULSE_LEN(PULSE_LEN)) uRos (
      .clock(clock),
      .rstn(rstn),
      .negTrig(&sRNeg),
      .posTrig(&sRPos),
      .clearIn(sRClr),
      .pulseOut(rosOut)
   );
   assign rosOutN = !rosOut;

   for (genvar i = 0; i < 2; i++) begin : gDual
      lep_retrig_os #(.PULSE_LEN(PULSE_LEN)) uDos (
         .clock(clock),
         .rstn(rstn),
         .negTrig(sDNeg[i]),
         .posTrig(sDPos[i]),
         .clearIn(sDClr[i]),
         .pulseOut(dosOut[i])
      );
   end
   assign dosOutN = ~dosOut;

   // rs flop: direct inputs act at once through the output mux
   logic rsClkPrev_reg;
   logic rs_reg;
   logic rsFall;
   assign rsFall = rsClkPrev_reg && !sRsClk;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rsClkPrev_reg <= 1'h0;
         rs_reg <= Q_RST;
      end else begin
         rsClkPrev_reg <= sRsClk;
         if (rsDirectClear) begin
            rs_reg <= 1'h0;
         end else if (rsDirectSet) begin
            rs_reg <= 1'h1;
         end else if (rsFall && (&sSetG)) begin
            rs_reg <= 1'h1;
         end else if (rsFall && (&sRstG)) begin
            rs_reg <= 1'h0;
         end
      end
   end
   assign rsQ = rsDirectClear ? 1'h0 : (rsDirectSet ? 1'h1 : rs_reg);
   assign rsQN = !rsQ;
   chk_rs_hold: assert property (@(posedge clock) disable iff (!rstn)
      !rsFall && !rsDirectSet && !rsDirectClear |=> rs_reg == $past(rs_reg))
      else $error("rs flop moved without falling clock");

   // nand latch: set 1 gives 0, reset 1 gives 1; both high keeps state
   logic nl_reg;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         nl_reg <= Q_RST;
      end else if (sNlS && !sNlR) begin
         nl_reg <= 1'h0;
      end else if (!sNlS && sNlR) begin
         nl_reg <= 1'h1;
      end
   end
   assign nlQ = nl_reg;
   assign nlQN = !nl_reg;

   // data latch, sampled form; preset and clear bypass the sync path
   logic dl_reg;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         dl_reg <= Q_RST;
      end else if (!dlClearN) begin
         dl_reg <= 1'h0;
      end else if (!dlPresetN) begin
         dl_reg <= 1'h1;
      end else if (sDlE) begin
         dl_reg <= sDlD;
      end
   end
   assign dlQ = !dlClearN ? 1'h0 : (!dlPresetN ? 1'h1 : dl_reg);
   assign dlQN = !dlQ;
   chk_latch_hold: assert property (@(posedge clock) disable iff (!rstn)
      !sDlE && dlPresetN && dlClearN |=> dl_reg == $past(dl_reg))
      else $error("latch moved while closed");

   // j-k flops, active on rising edge of the sampled element clock
   logic [1:0] jkClkPrev_reg;
   logic [1:0] jk_reg;
   logic [1:0] kEff;
   assign kEff = {!jkK[1], jkK[0]};
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         jkClkPrev_reg <= 2'h0;
      end else begin
         jkClkPrev_reg <= sJkClk;
      end
   end
   for (genvar i = 0; i < 2; i++) begin : gJk
      always_ff @(posedge clock or negedge rstn) begin
         if (!rstn) begin
            jk_reg[i] <= Q_RST;
         end else if (direct_clear_in[i]) begin
            jk_reg[i] <= 1'h0;
         end else if (direct_set_in[i]) begin
            jk_reg[i] <= 1'h1;
         end else if (sJkClk[i] && !jkClkPrev_reg[i]) begin
            case ({jkJ[i], kEff[i]})
               2'h3: jk_reg[i] <= !jk_reg[i];
               2'h2: jk_reg[i] <= 1'h1;
               2'h1: jk_reg[i] <= 1'h0;
               default: jk_reg[i] <= jk_reg[i];
            endcase
         end
      end
      assign jkQ[i] = direct_clear_in[i] ? 1'h0
         : (direct_set_in[i] ? 1'h1 : jk_reg[i]);
   end
   assign jkQN = ~jkQ;
   chk_jk_toggle: assert property (@(posedge clock) disable iff (!rstn)
      sJkClk[0] && !jkClkPrev_reg[0] && jkJ[0] && jkK[0]
      && !direct_set_in[0] && !direct_clear_in[0]
      |=> jk_reg[0] != $past(jk_reg[0]))
      else $error("jk did not toggle");
   chk_gated_len: assert property (@(posedge clock) disable iff (!rstn)
      $rose(gosOut) |-> gCount_reg == PULSE_W'(PULSE_LEN))
      else $error("gated pulse length wrong");
   chk_aoi_low: assert property (@(posedge clock) disable iff (!rstn)
      (&aoiDualIn[1:0]) |-> !aoiDualOut)
      else $error("aoi output not low");
   chk_xor_out: assert property (@(posedge clock) disable iff (!rstn)
      xorOut == (xorA != xorB)) else $error("xor wrong");
   initial begin
      if (PULSE_LEN < 1 || PULSE_LEN >= (1 << PULSE_W)) begin
         $error("pulse length out of range");
      end
   end
endmodule : lep_top

//--- sim/lep_elem_drv.sv
`timescale 1ns/10ps

module lep_elem_drv
   import lep_pkg::*;
#(
   parameter int HIGH_CYC = 6
) (
   // system
   input wire logic clock,
   input wire logic rstn,
   // one bit per element clock
   input wire logic [2:0] pulseReq,
   output logic [2:0] elemClk
);
   logic [3:0] cnt_reg;

   // whole-cycle high and low phases so the synchroniser sees both
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cnt_reg <= 4'h0;
         elemClk <= 3'h0;
      end else if (cnt_reg != 4'h0) begin
         cnt_reg <= cnt_reg - 4'h1;
         if (cnt_reg == 4'(HIGH_CYC)) begin
            elemClk <= 3'h0;
         end
      end else if (pulseReq != 3'h0) begin
         cnt_reg <= 4'(2 * HIGH_CYC);
         elemClk <= pulseReq;
      end
   end
endmodule : lep_elem_drv

//--- sim/lep_top_tb.sv
`timescale 1ns/10ps

module lep_top_tb
   import lep_pkg::*;
;
   logic clock, rstn, aoiDualOut, aoiQuadOut, xorA, xorB, xorOut;
   logic [3:0] aoiDualIn;
   logic [7:0] aoiQuadIn;
   logic neg_trigger_first, neg_trigger_second, gosPosTrig, gosOut, gosOutN;
   logic [1:0] rosNegTrig, rosPosTrig, dosNegTrig, dosPosTrig, dosClearN;
   logic rosClearN, rosOut, rosOutN, rsDirectSet, rsDirectClear, rsQ, rsQN;
   logic [1:0] dosOut, dosOutN, rsSetGate, rsResetGate, jkJ, jkK, jkQ, jkQN;
   logic nlSet, nlReset, nlQ, nlQN, dlData, dlEnable, dlPresetN, dlClearN;
   logic dlQ, dlQN;
   logic [1:0] direct_set_in, direct_clear_in;
   logic [2:0] pulseReq, elemClk;
   int badCount = 0;
   int samplesChecked = 0;

   lep_top #(.PULSE_LEN(6)) i_dut (.clock, .rstn, .aoiDualIn, .aoiDualOut,
      .aoiQuadIn, .aoiQuadOut, .xorA, .xorB, .xorOut, .neg_trigger_first,
      .neg_trigger_second, .gosPosTrig, .gosOut, .gosOutN, .rosNegTrig,
      .rosPosTrig, .rosClearN, .rosOut, .rosOutN, .dosNegTrig, .dosPosTrig,
      .dosClearN, .dosOut, .dosOutN, .rsClk(elemClk[0]), .rsSetGate,
      .rsResetGate, .rsDirectSet, .rsDirectClear, .rsQ, .rsQN, .nlSet,
      .nlReset, .nlQ, .nlQN, .dlData, .dlEnable, .dlPresetN, .dlClearN, .dlQ,
      .dlQN, .jkClk(elemClk[2:1]), .jkJ, .jkK, .direct_set_in,
      .direct_clear_in, .jkQ, .jkQN);
   lep_elem_drv #(.HIGH_CYC(6)) i_drv (.clock, .rstn, .pulseReq, .elemClk);

   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   task automatic conclude;
      if (badCount == 0 && samplesChecked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : conclude

   task automatic check(input string what, input logic [1:0] seen,
                        input logic [1:0] exp);
      samplesChecked++;
      if (seen !== exp) begin
         badCount++;
         $display("MISMATCH %s expected %b seen %b", what, exp, seen);
      end
   endtask : check

   task automatic cyc(input int n);
      repeat (n) @(negedge clock);
   endtask : cyc

   // request lands mid high phase on return
   task automatic strobe(input logic [2:0] r);
      pulseReq = r;
      cyc(1);
      pulseReq = 3'h0;
      cyc(4);
   endtask : strobe

   task automatic t_comb;
      logic e;
      for (int i = 0; i < 256; i++) begin
         aoiQuadIn = 8'(i);
         aoiDualIn = 4'(i);
         {xorA, xorB} = 2'(i);
         #1;
         e = 1'b1;
         for (int g = 0; g < 4; g++) begin
            if (aoiQuadIn[2*g] && aoiQuadIn[2*g+1]) begin
               e = 1'b0;
            end
         end
         check("aoi quad", {1'b0, aoiQuadOut}, {1'b0, e});
         e = !(aoiDualIn[0] && aoiDualIn[1] || aoiDualIn[2] && aoiDualIn[3]);
         check("aoi dual", {1'b0, aoiDualOut}, {1'b0, e});
         check("xor", {1'b0, xorOut}, {1'b0, xorA != xorB});
         cyc(1);
      end
   endtask : t_comb

   task automatic t_gos;
      neg_trigger_first = 1'b0;
      cyc(4);
      check("gos idle", {gosOut, gosOutN}, 2'b01);
      gosPosTrig = 1'b1;
      cyc(4);
      check("gos pos", {gosOut, gosOutN}, 2'b10);
      gosPosTrig = 1'b0;
      cyc(1);
      gosPosTrig = 1'b1;
      cyc(7);
      check("gos end", {gosOut, gosOutN}, 2'b01);
      neg_trigger_first = 1'b1;
      cyc(4);
      neg_trigger_second = 1'b0;
      cyc(4);
      check("gos neg", {gosOut, gosOutN}, 2'b10);
      neg_trigger_second = 1'b1;
      gosPosTrig = 1'b0;
      cyc(8);
   endtask : t_gos

   task automatic fire_ros;
      rosPosTrig = 2'b01;
      cyc(1);
      rosPosTrig = 2'b11;
   endtask : fire_ros

   task automatic t_ros;
      rosPosTrig = 2'b11;
      cyc(4);
      fire_ros();
      cyc(6);
      check("ros retrig", {rosOut, rosOutN}, 2'b10);
      cyc(10);
      check("ros end", {rosOut, rosOutN}, 2'b01);
      fire_ros();
      cyc(4);
      rosClearN = 1'b0;
      cyc(4);
      check("ros cut", {rosOut, rosOutN}, 2'b01);
      fire_ros();
      cyc(4);
      check("ros blocked", {rosOut, rosOutN}, 2'b01);
      rosClearN = 1'b1;
      cyc(4);
      check("ros clear fire", {rosOut, rosOutN}, 2'b10);
      rosPosTrig = 2'b01;
      cyc(10);
   endtask : t_ros

   task automatic t_dos;
      for (int c = 0; c < 2; c++) begin
         dosPosTrig[c] = 1'b1;
         cyc(4);
         check("dos out", dosOut, 2'(1 << c));
         check("dos outn", dosOutN, ~2'(1 << c));
         dosPosTrig[c] = 1'b0;
         cyc(10);
         // neg high blocks the rising pos; a later falling neg fires
         {dosNegTrig[c], dosPosTrig[c]} = 2'h3;
         cyc(4);
         check("dos neg block", dosOut, 2'h0);
         dosNegTrig[c] = 1'b0;
         cyc(4);
         check("dos neg fire", dosOut, 2'(1 << c));
         dosPosTrig[c] = 1'b0;
         cyc(10);
      end
   endtask : t_dos

   // gates never all four high together
   task automatic t_rs;
      rsSetGate = 2'b11;
      strobe(3'b001);
      check("rs clk high", {rsQ, rsQN}, 2'b01);
      cyc(10);
      check("rs set", {rsQ, rsQN}, 2'b10);
      rsSetGate = 2'b01;
      rsResetGate = 2'b01;
      strobe(3'b001);
      cyc(10);
      check("rs hold", {rsQ, rsQN}, 2'b10);
      rsSetGate = 2'b00;
      rsResetGate = 2'b11;
      strobe(3'b001);
      cyc(10);
      check("rs clear", {rsQ, rsQN}, 2'b01);
      rsResetGate = 2'b00;
      rsDirectSet = 1'b1;
      #1;
      check("rs dset", {rsQ, rsQN}, 2'b10);
      cyc(1);
      rsDirectSet = 1'b0;
      rsDirectClear = 1'b1;
      #1;
      check("rs dclear", {rsQ, rsQN}, 2'b01);
      cyc(1);
      rsDirectClear = 1'b0;
   endtask : t_rs

   task automatic t_latch;
      logic [1:0] sr[4] = '{2'b01, 2'b00, 2'b10, 2'b00};
      logic [1:0] nq[4] = '{2'b10, 2'b10, 2'b01, 2'b01};
      logic [1:0] de[5] = '{2'b11, 2'b01, 2'b11, 2'b10, 2'b00};
      logic [1:0] dq[5] = '{2'b10, 2'b01, 2'b10, 2'b10, 2'b10};
      for (int i = 0; i < 4; i++) begin
         {nlSet, nlReset} = sr[i];
         cyc(4);
         check("nand latch", {nlQ, nlQN}, nq[i]);
      end
      for (int i = 0; i < 5; i++) begin
         {dlData, dlEnable} = de[i];
         cyc(4);
         check("data latch", {dlQ, dlQN}, dq[i]);
      end
      dlClearN = 1'b0;
      #1;
      check("dl clear", {dlQ, dlQN}, 2'b01);
      cyc(1);
      dlClearN = 1'b1;
      dlPresetN = 1'b0;
      #1;
      check("dl preset", {dlQ, dlQN}, 2'b10);
      cyc(1);
      dlPresetN = 1'b1;
   endtask : t_latch

   task automatic t_jk;
      logic [1:0] j[5] = '{2'b11, 2'b10, 2'b01, 2'b10, 2'b01};
      logic [1:0] k[5] = '{2'b10, 2'b00, 2'b01, 2'b01, 2'b11};
      logic [1:0] q[5] = '{2'b11, 2'b01, 2'b00, 2'b10, 2'b11};
      for (int i = 0; i < 5; i++) begin
         jkJ = j[i];
         jkK = k[i];
         strobe(3'b110);
         check("jk q", jkQ, q[i]);
         cyc(10);
      end
      direct_clear_in = 2'b11;
      #1;
      check("jk dclear", jkQN, 2'b11);
      cyc(1);
      direct_clear_in = 2'b00;
      direct_set_in = 2'b11;
      #1;
      check("jk dset", jkQ, 2'b11);
      cyc(1);
      direct_set_in = 2'b00;
   endtask : t_jk

   initial begin
      rstn = 1'b0;
      {aoiDualIn, aoiQuadIn, xorA, xorB, gosPosTrig} = '0;
      {neg_trigger_first, neg_trigger_second} = 2'b11;
      {rosNegTrig, rosPosTrig, rosClearN} = 5'h03;
      {dosNegTrig, dosPosTrig, dosClearN} = 6'h03;
      {rsSetGate, rsResetGate, rsDirectSet, rsDirectClear} = '0;
      {nlSet, nlReset, dlData, dlEnable} = '0;
      // latch follows data only with both held high
      {dlPresetN, dlClearN} = 2'b11;
      {jkJ, jkK, direct_set_in, direct_clear_in, pulseReq} = '0;
      repeat (8) @(negedge clock);
      rstn = 1'b1;
      cyc(4);
      check("rs reset", {rsQ, rsQN}, 2'b01);
      t_comb();
      t_gos();
      t_ros();
      t_dos();
      t_rs();
      t_latch();
      t_jk();
      conclude();
   end

   initial begin
      repeat (5000) @(posedge clock);
      badCount++;
      conclude();
   end
endmodule : lep_top_tb
